// ==== bench/madc_host.sv ====
// madc_host: host processor side of the io transfer bus
// assumes commands are launched and released on falling edges of clk
`timescale 1ns/100ps
`default_nettype none
module madc_host (
  input  wire logic        clk,        // host io clock
  output logic [5:0]       dev_sel,    // device select code
  output logic [2:0]       io_pulse,   // command pulse lines
  output logic [11:0]      host_data,  // accumulator lines
  input  wire logic [11:0] data_out,   // data ORed in by device
  input  wire logic        data_valid, // device drives data
  input  wire logic        skip        // skip request
);
  logic [11:0] acc;
  logic        skipped;
  initial begin
    dev_sel   = 6'h00;
    io_pulse  = 3'h0;
    host_data = 12'h000;
    acc       = 12'h000;
    skipped   = 1'b0;
  end
  task automatic io_xfer(input logic [5:0] d, input logic [2:0] p, input logic [11:0] v);
    @(negedge clk);
    // the device only ORs onto the lines, so the accumulator starts clear
    acc       = 12'h000;
    dev_sel   = d;
    io_pulse  = p;
    host_data = v;
    #2 skipped = skip;
    @(negedge clk);
    if (data_valid === 1'b1)
      acc = acc | data_out;
    io_pulse  = 3'h0;
    // released lines must not keep their last value
    dev_sel   = ~d;
    host_data = ~v;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// tb: self-checking bench for madc_ctrl driven by the host model
// assumes madc_pkg and madc_host are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [5:0] CV = madc_pkg::DEV_CONV;
  localparam logic [5:0] MX = madc_pkg::DEV_MUX;
  localparam logic [2:0] P1 = madc_pkg::PULSE_1;
  localparam logic [2:0] P2 = madc_pkg::PULSE_2;
  localparam logic [2:0] P4 = madc_pkg::PULSE_4;
  logic        clk, rst, seq, fast, amp, sh, int_en, dv, skip, done, irq, busy;
  logic [3:0]  wl, pnl;
  logic [5:0]  dev, rchan, cmax, chan;
  logic [2:0]  io_command_pulse;
  logic [11:0] hdata, sar, dout;
  int          fails = 0;
  int          num_checks = 0;
  int          n;

  madc_host madc_host_i (.clk(clk), .dev_sel(dev), .io_pulse(io_command_pulse), .host_data(hdata),
    .data_out(dout), .data_valid(dv), .skip(skip));
  madc_ctrl madc_ctrl_i (.REF_CLK(clk), .SYS_RST(rst), .DEV_SEL(dev), .IO_PULSE(io_command_pulse),
    .HOST_DATA(hdata), .SEQ_MODE(seq), .RAND_CHAN(rchan), .RAND_LOAD(pnl[3]),
    .FAST_MODE(fast), .AMP_FITTED(amp), .SH_FITTED(sh), .INT_ENABLE(int_en),
    .WORD_LEN(wl), .CHAN_MAX(cmax), .PANEL_CLEAR(pnl[0]), .PANEL_INDEX(pnl[1]),
    .PANEL_CONV(pnl[2]), .SAR_RESULT(sar), .MUX_CHAN(chan), .DATA_OUT(dout),
    .DATA_VALID(dv), .SKIP(skip), .DONE(done), .INT_REQ(irq), .BUSY(busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check_val(input logic [11:0] got, input logic [11:0] exp, input string s);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask

  // a few cycles of slack cover where the count starts against the command edge
  task automatic check_near(input int got, input int exp, input string s);
    num_checks++;
    if (got < exp - 4 || got > exp + 4) begin
      fails++;
      $display("wrong value at %0t: %s took %0d cycles, not %0d", $time, s, got, exp);
    end
  endtask

  task automatic strobe(input logic [3:0] m);
    @(negedge clk);
    pnl = m;
    @(negedge clk);
    pnl = 4'h0;
  endtask

  task automatic wait_done();
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic cmd(input logic [5:0] d, input logic [2:0] p, input logic [11:0] v);
    madc_host_i.io_xfer(d, p, v);
  endtask

  task automatic t_set_convert();
    check_val({6'h00, chan}, 12'h000, "channel after reset");
    check_val({8'h00, done, irq, busy, dv}, 12'h000, "flags after reset");
    cmd(MX, P2, 12'hFD5);
    check_val({6'h00, chan}, 12'h015, "channel from low data bits");
    check_val({11'h000, busy}, 12'h001, "settling after set");
    wait_done();
    check_near(n, 1100, "settle then 6 bit conversion");
    check_val({11'h000, irq}, 12'h001, "interrupt on ready word");
    cmd(CV, P1, 12'h000);
    check_val({11'h000, madc_host_i.skipped}, 12'h001, "skip when done");
    cmd(CV, P4, 12'h000);
    check_val(madc_host_i.acc, 12'hA80, "left-justified 6 bit result");
    check_val({10'h000, done, irq}, 12'h000, "read clears done");
    cmd(CV, P1, 12'h000);
    check_val({11'h000, madc_host_i.skipped}, 12'h000, "no skip when clear");
    $display("test set and convert finished");
  endtask

  task automatic t_timing();
    int         exp [4] = '{1400, 1900, 950, 2000};
    logic [6:0] cfg [4] = '{7'h46, 7'h26, 7'h16, 7'h1A};
    for (int i = 0; i < 4; i++) begin
      {amp, sh, fast, wl} = cfg[i];
      cmd(MX, P2, 12'(i + 2));
      wait_done();
      check_near(n, exp[i], "settle and conversion with options");
      cmd(CV, P4, 12'h000);
    end
    {amp, sh, fast, wl} = 7'h06;
    $display("test option timings finished");
  endtask

  task automatic t_convert();
    cmd(CV, P2, 12'h000);
    wait_done();
    check_near(n, 900, "6 bit conversion on same channel");
    wl = 4'hC;
    cmd(CV, P2, 12'h000);
    check_val({10'h000, done, busy}, 12'h001, "convert clears done");
    wait_done();
    check_near(n, 3500, "12 bit conversion on same channel");
    cmd(CV, P4, 12'h000);
    check_val(madc_host_i.acc, 12'hABC, "full 12 bit result");
    wl = 4'h6;
    $display("test convert command finished");
  endtask

  task automatic t_channel();
    cmax = 6'h05;
    cmd(MX, P2, 12'h005);
    cmd(MX, P4, 12'h000);
    check_val({6'h00, chan}, 12'h000, "increment wraps from maximum");
    cmd(6'h2A, P2, 12'h003);
    check_val({6'h00, chan}, 12'h000, "foreign device code ignored");
    cmd(MX, P2, 12'h003);
    cmd(MX, P1, 12'h000);
    check_val({6'h00, chan}, 12'h000, "clear channel command");
    seq = 1'b1;
    strobe(4'h8);
    check_val({6'h00, chan}, 12'h000, "select levels ignored");
    repeat (5) strobe(4'h2);
    check_val({6'h00, chan}, 12'h005, "index up to highest channel");
    strobe(4'h2);
    check_val({6'h00, chan}, 12'h000, "index wraps to zero");
    seq = 1'b0;
    strobe(4'h8);
    check_val({6'h00, chan}, 12'h009, "random select routes channel");
    wait_done();
    cmd(CV, P4, 12'h000);
    strobe(4'h4);
    check_val({11'h000, busy}, 12'h001, "panel convert starts");
    wait_done();
    check_near(n, 900, "panel conversion on current channel");
    strobe(4'h1);
    check_val({6'h00, chan}, 12'h000, "panel clear");
    cmax = 6'h3F;
    $display("test channel control finished");
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    {rst, seq, fast, amp, sh, int_en, pnl} = 10'h200;
    {wl, rchan, cmax, sar} = {4'h6, 6'h09, 6'h3F, 12'hABC};
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    int_en = 1'b1;
    t_set_convert();
    t_timing();
    t_convert();
    t_channel();
    close_out();
  end

  // the whole run needs about 14000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire

// ==== rtl/madc_ctrl.sv ====
// madc_ctrl: control for a 64-channel multiplexer feeding a SAR converter
// assumes host command pulses synchronous to REF_CLK, one cycle wide
// Summary of operation
// - settle 2 us after set or increment
// - random mode routes last selected channel
// - sequential index adds one, wraps to 0
// - sequential mode ignores random select levels
// - conversion starts itself after settling ends
// - channel change adds 2 us, amplifier 3
// - sample-hold adds 10 us in total
// - word length 6 to 12, table times
// - below 10 bits reduced timings allowed
// - panel clear zeroes, panel index increments
// - panel convert starts on current channel
// - act only on own device code
// - skip request when done flag set
// - convert clears done, converts, sets done
// - read result left-justified, clears done
// - clear channel zeroes address register
// - set channel loads host bits 6-11
// - increment wraps from maximum to 00
// - interrupt each time a word is ready
`timescale 1ns/100ps
`default_nettype none
module madc_ctrl (
  input  wire logic        REF_CLK,       // 100 MHz clock
  input  wire logic        SYS_RST,       // sync reset, high
  input  wire logic [5:0]  DEV_SEL,       // device select code
  input  wire logic [2:0]  IO_PULSE,      // io_command_pulse lines 1,2,4
  input  wire logic [11:0] HOST_DATA,     // host accumulator lines
  input  wire logic        SEQ_MODE,      // sequential addressing mode
  input  wire logic [5:0]  RAND_CHAN,     // random-mode select levels
  input  wire logic        RAND_LOAD,     // random-mode select strobe
  input  wire logic        FAST_MODE,     // run reduced timings below 10 bits
  input  wire logic        AMP_FITTED,    // buffer amplifier option
  input  wire logic        SH_FITTED,     // sample-and-hold option
  input  wire logic        INT_ENABLE,    // interrupt operation enable
  input  wire logic [3:0]  WORD_LEN,      // word length switch 6..12
  input  wire logic [5:0]  CHAN_MAX,      // highest implemented channel
  input  wire logic        PANEL_CLEAR,   // panel_clear_channel pulse
  input  wire logic        PANEL_INDEX,   // panel index pulse
  input  wire logic        PANEL_CONV,    // panel convert pulse
  input  wire logic [11:0] SAR_RESULT,    // converter result, left-justified
  output logic [5:0]       MUX_CHAN,      // channel driven to multiplexer
  output logic [11:0]      DATA_OUT,      // data ORed onto host lines
  output logic             DATA_VALID,    // DATA_OUT is being driven
  output logic             SKIP,          // skip request
  output logic             DONE,          // conversion-done flag
  output logic             INT_REQ,       // interrupt request
  output logic             BUSY           // settling or converting
);
  madc_pkg::madc_state_t state;
  madc_pkg::madc_state_t next_state;
  logic [madc_pkg::CNT_W-1:0]  cnt;
  logic [madc_pkg::CNT_W-1:0]  next_cnt;
  logic [12:0]                 conv_cyc;
  logic [11:0]                 result;
  logic [3:0]                  wl_eff;
  logic                        fast_eff;

  // decode of host commands
  wire conv_dev = (DEV_SEL == madc_pkg::DEV_CONV);
  wire mux_dev  = (DEV_SEL == madc_pkg::DEV_MUX);
  wire skip_on_convert_done  = conv_dev && IO_PULSE == madc_pkg::PULSE_1;
  wire start_conversion_cmd  = conv_dev && IO_PULSE == madc_pkg::PULSE_2;
  wire read_result_cmd       = conv_dev && IO_PULSE == madc_pkg::PULSE_4;
  wire clear_channel_cmd     = mux_dev && IO_PULSE == madc_pkg::PULSE_1;
  wire set_channel_cmd       = mux_dev && IO_PULSE == madc_pkg::PULSE_2;
  wire increment_channel_cmd = mux_dev && IO_PULSE == madc_pkg::PULSE_4;

  // the channel register; a host or panel clear wins, then host set, random select, index
  logic [5:0] channel_address_register;
  logic [5:0] next_chan;
  wire        do_inc    = increment_channel_cmd || PANEL_INDEX;
  wire        rand_sel  = !SEQ_MODE && RAND_LOAD;
  wire [5:0]  inc_chan  = (channel_address_register >= CHAN_MAX) ?
                          madc_pkg::CHAN_ZERO : channel_address_register + 6'h01;
  wire [5:0]  host_chan = HOST_DATA[madc_pkg::CHAN_LSB +: madc_pkg::CHAN_W];
  always_comb begin
    next_chan = channel_address_register;
    if (clear_channel_cmd || PANEL_CLEAR) begin
      next_chan = madc_pkg::CHAN_ZERO;
    end else if (set_channel_cmd) begin
      next_chan = host_chan;
    end else if (rand_sel) begin
      next_chan = RAND_CHAN;
    end else if (do_inc) begin
      next_chan = inc_chan;
    end
  end
  wire chan_start = set_channel_cmd || rand_sel || do_inc;
  wire conv_start = start_conversion_cmd || PANEL_CONV;

  // word length clamp and reduced timing only under 10 bits
  assign wl_eff   = (WORD_LEN < 4'(madc_pkg::WL_MIN)) ? 4'(madc_pkg::WL_MIN) :
                    (WORD_LEN > 4'(madc_pkg::WL_MAX)) ? 4'(madc_pkg::WL_MAX) : WORD_LEN;
  assign fast_eff = FAST_MODE && (wl_eff < 4'hA);

  madc_rom u_rom (
    .clk    (REF_CLK),
    .wl     (wl_eff),
    .fast   (fast_eff),
    .cycles (conv_cyc)
  );

  // settle length: sample-hold overlaps switch settling, else 2 us plus amp
  wire [madc_pkg::CNT_W-1:0] settle_len =
    SH_FITTED  ? madc_pkg::CNT_W'(madc_pkg::SH_CYC) :
    AMP_FITTED ? madc_pkg::CNT_W'(madc_pkg::SETTLE_CYC + madc_pkg::AMP_CYC) :
                 madc_pkg::CNT_W'(madc_pkg::SETTLE_CYC);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    if (chan_start) begin
      // a new channel restarts settling, abandoning any conversion in flight
      next_state = madc_pkg::MADC_SETTLE;
      next_cnt   = settle_len - madc_pkg::CNT_W'(1);
    end else begin
      case (state)
        madc_pkg::MADC_IDLE: begin
          if (conv_start) begin
            next_state = madc_pkg::MADC_CONV;
            next_cnt   = conv_cyc - 13'h0001;
          end
        end
        madc_pkg::MADC_SETTLE: begin
          if (cnt == '0) begin
            next_state = madc_pkg::MADC_CONV;
            next_cnt   = conv_cyc - 13'h0001;
          end else begin
            next_cnt = cnt - madc_pkg::CNT_W'(1);
          end
        end
        madc_pkg::MADC_CONV: begin
          if (cnt == '0) begin
            next_state = madc_pkg::MADC_IDLE;
          end else begin
            next_cnt = cnt - madc_pkg::CNT_W'(1);
          end
        end
        default: next_state = madc_pkg::MADC_IDLE;
      endcase
    end
  end

  // no channel source of higher priority than an index in this cycle
  wire inc_only   = !clear_channel_cmd && !PANEL_CLEAR && !set_channel_cmd && !rand_sel;
  wire conv_done  = (state == madc_pkg::MADC_CONV) && (cnt == '0) && !chan_start;
  wire conv_begin = (next_state == madc_pkg::MADC_CONV) && (state != madc_pkg::MADC_CONV);
  // unused low bits forced to zero for short word lengths
  wire [11:0] wl_mask = 12'hFFF << (4'(madc_pkg::WL_MAX) - wl_eff);

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state                    <= madc_pkg::MADC_IDLE;
      cnt                      <= '0;
      channel_address_register <= madc_pkg::CHAN_ZERO;
      result                   <= 12'h000;
    end else begin
      state                    <= next_state;
      cnt                      <= next_cnt;
      channel_address_register <= next_chan;
      if (conv_done) begin
        result <= SAR_RESULT & wl_mask;
      end
    end
  end

  // done flag: completion wins over a clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      DONE    <= 1'b0;
      INT_REQ <= 1'b0;
    end else begin
      if (conv_done) begin
        DONE <= 1'b1;
      end else if (conv_begin || read_result_cmd) begin
        DONE <= 1'b0;
      end
      INT_REQ <= INT_ENABLE && (conv_done ||
                 (DONE && !(conv_begin || read_result_cmd)));
    end
  end

  // host data lines are ORed by the host, so only a valid read drives them
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      DATA_OUT   <= 12'h000;
      DATA_VALID <= 1'b0;
    end else begin
      DATA_OUT   <= read_result_cmd ? result : 12'h000;
      DATA_VALID <= read_result_cmd;
    end
  end

  assign SKIP     = skip_on_convert_done && DONE;
  assign MUX_CHAN = channel_address_register;
  assign BUSY     = (state != madc_pkg::MADC_IDLE);

  // ---- checks
  sequence settle_s;
    state == madc_pkg::MADC_SETTLE && cnt == '0 && !chan_start;
  endsequence
  sequence conv_end_s;
    state == madc_pkg::MADC_CONV && cnt == '0 && !chan_start;
  endsequence
  sequence done_rise_s;
    DONE && !BUSY;
  endsequence
  settle_to_conv_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    settle_s |=> state == madc_pkg::MADC_CONV)
    else $error("settling did not start conversion");
  chan_settle_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    set_channel_cmd |=> state == madc_pkg::MADC_SETTLE)
    else $error("set channel did not start settling");
  settle_len_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (set_channel_cmd && !SH_FITTED && !AMP_FITTED) |=> cnt == 13'h00C7)
    else $error("settle count wrong");
  sh_len_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (set_channel_cmd && SH_FITTED) |=> cnt == 13'h03E7)
    else $error("sample-hold settle count wrong");
  clear_chan_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    clear_channel_cmd |=> MUX_CHAN == 6'h00)
    else $error("clear channel failed");
  set_chan_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (set_channel_cmd && !clear_channel_cmd && !PANEL_CLEAR) |=> MUX_CHAN == $past(HOST_DATA[5:0]))
    else $error("set channel failed");
  inc_wrap_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (increment_channel_cmd && !clear_channel_cmd && !PANEL_CLEAR && !set_channel_cmd && !rand_sel
     && MUX_CHAN >= CHAN_MAX) |=> MUX_CHAN == 6'h00)
    else $error("increment did not wrap");
  seq_ignore_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (SEQ_MODE && !clear_channel_cmd && !PANEL_CLEAR && !set_channel_cmd && !do_inc)
    |=> $stable(MUX_CHAN))
    else $error("sequential mode took select levels");
  skip_flag_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    skip_on_convert_done |-> SKIP == DONE)
    else $error("skip mismatch");
  done_set_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    conv_end_s |=> done_rise_s)
    else $error("done not set");
  read_clear_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (read_result_cmd && !conv_done) |=> !DONE && DATA_VALID && DATA_OUT == $past(result))
    else $error("read failed");
  int_req_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (conv_done && INT_ENABLE) |=> INT_REQ)
    else $error("no interrupt on ready word");
  idle_reset_a: assert property (@(posedge REF_CLK)
    SYS_RST |=> state == madc_pkg::MADC_IDLE && !DONE && !INT_REQ && MUX_CHAN == 6'h00)
    else $error("reset state wrong");
  // the table answers one cycle after the word length it was given
  fast_wl_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (wl_eff == 4'hA) |=> conv_cyc == 13'h0708)
    else $error("reduced timing at 10 bits or more");
  fast_six_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (wl_eff == 4'h6 && fast_eff) |=> conv_cyc == 13'h02EE)
    else $error("reduced 6 bit time wrong");
  slow_six_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (wl_eff == 4'h6 && !fast_eff) |=> conv_cyc == 13'h0384)
    else $error("6 bit time wrong");
  full_len_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (wl_eff == 4'hC) |=> conv_cyc == 13'h0DAC)
    else $error("12 bit time wrong");
  wl_clamp_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (WORD_LEN < 4'h6) |-> wl_eff == 4'h6)
    else $error("word length not clamped");
  idle_conv_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state == madc_pkg::MADC_IDLE && start_conversion_cmd && !chan_start)
    |=> state == madc_pkg::MADC_CONV && !DONE)
    else $error("convert command did not start");
  panel_conv_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state == madc_pkg::MADC_IDLE && PANEL_CONV && !chan_start)
    |=> state == madc_pkg::MADC_CONV && $stable(MUX_CHAN))
    else $error("panel convert did not start");
  busy_ignore_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state == madc_pkg::MADC_CONV && cnt != '0 && !chan_start)
    |=> state == madc_pkg::MADC_CONV && cnt == $past(cnt) - 13'h0001)
    else $error("conversion count broken");
  settle_count_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state == madc_pkg::MADC_SETTLE && cnt != '0 && !chan_start)
    |=> state == madc_pkg::MADC_SETTLE && cnt == $past(cnt) - 13'h0001)
    else $error("settle count broken");
  conv_load_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    settle_s |=> cnt == $past(conv_cyc) - 13'h0001)
    else $error("conversion length not loaded");
  settle_amp_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (set_channel_cmd && !SH_FITTED && AMP_FITTED) |=> cnt == 13'h01F3)
    else $error("amplifier settle count wrong");
  rand_settle_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (rand_sel && !SH_FITTED && !AMP_FITTED) |=> cnt == 13'h00C7)
    else $error("random select settle wrong");
  abort_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state == madc_pkg::MADC_CONV && chan_start && !DONE) |=> !DONE)
    else $error("aborted conversion set done");
  foreign_code_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!conv_dev && !mux_dev && inc_only && !PANEL_INDEX && !PANEL_CONV
     && state == madc_pkg::MADC_IDLE) |=> state == madc_pkg::MADC_IDLE && $stable(MUX_CHAN))
    else $error("foreign code acted on");
  rand_route_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (rand_sel && !clear_channel_cmd && !PANEL_CLEAR && !set_channel_cmd)
    |=> MUX_CHAN == $past(RAND_CHAN))
    else $error("random channel not routed");
  panel_clear_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    PANEL_CLEAR |=> MUX_CHAN == 6'h00)
    else $error("panel clear failed");
  panel_index_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (PANEL_INDEX && inc_only && MUX_CHAN < CHAN_MAX) |=> MUX_CHAN == $past(MUX_CHAN) + 6'h01)
    else $error("panel index failed");
  seq_wrap_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (SEQ_MODE && PANEL_INDEX && inc_only && MUX_CHAN >= CHAN_MAX) |=> MUX_CHAN == 6'h00)
    else $error("sequential index did not wrap");
  inc_step_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (increment_channel_cmd && inc_only && MUX_CHAN < CHAN_MAX)
    |=> MUX_CHAN == $past(MUX_CHAN) + 6'h01)
    else $error("increment failed");
  done_hold_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (DONE && !conv_begin && !read_result_cmd) |=> DONE)
    else $error("done dropped by itself");
  done_quiet_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!DONE && !conv_done) |=> !DONE)
    else $error("done rose without a result");
  int_follow_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    INT_ENABLE |=> INT_REQ == DONE)
    else $error("interrupt not tied to done");
  int_off_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !INT_ENABLE |=> !INT_REQ)
    else $error("interrupt while disabled");
  read_data_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    read_result_cmd |=> DATA_VALID)
    else $error("read gave no data");
  data_idle_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !read_result_cmd |=> DATA_OUT == 12'h000 && !DATA_VALID)
    else $error("data lines driven without read");
  skip_quiet_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !skip_on_convert_done |-> !SKIP)
    else $error("skip without command");
  rst_data_a: assert property (@(posedge REF_CLK)
    SYS_RST |=> !DATA_VALID && DATA_OUT == 12'h000 && !BUSY)
    else $error("reset outputs wrong");
endmodule
`default_nettype wire

// ==== rtl/madc_pkg.sv ====
// madc_pkg: constants shared by the multiplexed converter control
// assumes a 100 MHz REF_CLK; host device codes arrive as 6-bit octal codes
package madc_pkg;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned SETTLE_US    = 2;
  localparam int unsigned AMP_US       = 3;
  localparam int unsigned SH_US        = 10;
  localparam int unsigned SETTLE_CYC   = SETTLE_US * CLK_MHZ;
  localparam int unsigned AMP_CYC      = AMP_US * CLK_MHZ;
  localparam int unsigned SH_CYC       = SH_US * CLK_MHZ;
  localparam int unsigned CNT_W        = 13;
  localparam int unsigned CHAN_W       = 6;
  localparam int unsigned DATA_W       = 12;
  localparam int unsigned WL_MIN       = 6;
  localparam int unsigned WL_MAX       = 12;
  localparam int unsigned CHAN_LSB     = 0;   // host bits 6..11 = low six data bits
  localparam logic [5:0]  DEV_CONV     = 6'h2B; // octal 53
  localparam logic [5:0]  DEV_MUX      = 6'h2C; // octal 54
  localparam logic [2:0]  PULSE_1      = 3'h1;
  localparam logic [2:0]  PULSE_2      = 3'h2;
  localparam logic [2:0]  PULSE_4      = 3'h4;
  localparam logic [5:0]  CHAN_ZERO    = 6'h00;
  localparam logic [CHAN_W-1:0] CHAN_MAX_DEF = 6'h3F;
  typedef enum logic [1:0] {
    MADC_IDLE   = 2'b00,
    MADC_SETTLE = 2'b01,
    MADC_CONV   = 2'b10
  } madc_state_t;
endpackage

// ==== rtl/madc_rom.sv ====
// madc_rom: conversion-time table indexed by word length and timing mode
// registered output; caller allows one cycle of latency
`timescale 1ns/100ps
`default_nettype none
module madc_rom (
  input  wire logic        clk,    // clock
  input  wire logic [3:0]  wl,     // word length 6..12
  input  wire logic        fast,   // reduced timings
  output logic [12:0]      cycles  // conversion cycles
);
  // tenths of a microsecond times ten cycles at 100 MHz
  function automatic logic [12:0] conv_time(input logic [3:0] w, input logic f);
    logic [12:0] t;
    t = 13'h0DAC;
    case (w)
      4'h6: t = f ? 13'h02EE : 13'h0384;
      4'h7: t = f ? 13'h0384 : 13'h041A;
      4'h8: t = f ? 13'h041A : 13'h04B0;
      4'h9: t = f ? 13'h04B0 : 13'h0546;
      4'hA: t = 13'h0708;
      4'hB: t = 13'h09C4;
      default: t = 13'h0DAC;
    endcase
    return t;
  endfunction
  always_ff @(posedge clk) begin
    cycles <= conv_time(wl, fast);
  end
endmodule
`default_nettype wire
